// file: oapl_pkg.sv
/*
  Package for the or-into-file / pointer-load decoder: opcode fields,
  encodings, address limits, phase count and reset values.
  Assumes a 16-bit instruction word and an 8-bit data path.
*/
`default_nettype none
package oapl_pkg;
  localparam logic [3:0]  OP_OR_HI        = 4'h1;
  localparam logic [1:0]  OP_OR_MID       = 2'h0;
  localparam logic [7:0]  OP_PTR_HI       = 8'hEE;
  localparam logic [1:0]  OP_PTR_MID      = 2'h0;
  localparam logic [7:0]  OP_PTR_W2_HI    = 8'hF0;
  localparam logic [7:0]  INDEXED_LIMIT   = 8'h5F;
  localparam logic [3:0]  ACCESS_BANK_LO  = 4'h0;
  localparam logic [3:0]  ACCESS_BANK_HI  = 4'hF;
  localparam logic [7:0]  ACCESS_SPLIT    = 8'h60;
  localparam logic [1:0]  PTR_COUNT       = 2'h3;
  localparam logic [1:0]  PHASE_LAST      = 2'h3;
  localparam logic [7:0]  WORK_RESET      = 8'h00;
  localparam logic [11:0] PTR_RESET       = 12'h000;
  localparam int          DIR_BIT         = 9;
  localparam int          ACC_BIT         = 8;
  typedef enum logic [1:0] {OAPL_PH_DECODE, OAPL_PH_READ, OAPL_PH_PROC, OAPL_PH_WRITE}
    oapl_phase_t;
  typedef enum logic [1:0] {OAPL_IDLE, OAPL_OR, OAPL_PTR1, OAPL_PTR2} oapl_state_t;
endpackage
`default_nettype wire

// file: oapl_ptr_reg.sv
/*
  One 12-bit indirect pointer split into high nibble and low byte.
  Assumes the loads are one-cycle enables from the decoder.
*/
`default_nettype none
module oapl_ptr_reg (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       load_high,
  input  wire logic       load_low,
  input  wire logic [3:0] high_in,
  input  wire logic [7:0] low_in,
  output logic      [11:0] ptr
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr[11:8] <= oapl_pkg::PTR_RESET[11:8];
    end else if (load_high) begin
      ptr[11:8] <= high_in;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr[7:0] <= oapl_pkg::PTR_RESET[7:0];
    end else if (load_low) begin
      ptr[7:0] <= low_in;
    end
  end
endmodule // oapl_ptr_reg
`default_nettype wire

// file: oapl_core.sv
/*
  Decode and execute of or-into-file and load-pointer-literal in a
  four-phase instruction cycle. Assumes instr is stable for a whole
  cycle and presented when instr_valid is high at phase decode; the
  file memory answers file_rdata combinationally to file_addr.
*/
// Behaviour
// - or work with file byte, flags N Z
// - direction bit picks work or file
// - access bit picks access or bank select
// - extended set: low addresses use indexed offset
// - load 12-bit literal into pointer 0..2
// - two words: high nibble, then low byte
`default_nettype none
module oapl_core (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] instr,
  input  wire logic        instr_valid,
  input  wire logic [3:0]  bank_select_register,
  input  wire logic        extended_enable,
  input  wire logic [7:0]  file_rdata,
  output logic      [11:0] file_addr,
  output logic      [7:0]  file_wdata,
  output logic             file_we,
  output logic      [7:0]  work_reg,
  output logic             flag_negative,
  output logic             flag_zero,
  output logic      [11:0] indirect_pointer0,
  output logic      [11:0] indirect_pointer1,
  output logic      [11:0] indirect_pointer2,
  output logic      [1:0]  phase,
  output logic             busy,
  output logic             illegal
);
  oapl_pkg::oapl_phase_t phase_reg;
  oapl_pkg::oapl_state_t state_reg;
  oapl_pkg::oapl_state_t state_next;
  logic [15:0] ir_reg;
  logic [7:0]  result_reg;
  logic [1:0]  sel_reg;
  logic [3:0]  khigh_reg;
  logic        is_or;
  logic        is_ptr;
  logic        is_w2;
  logic        at_end;
  logic [7:0]  faddr;
  logic [11:0] ptrs [3];
  logic [2:0]  ld_hi;
  logic [2:0]  ld_lo;
  logic [11:0] addr_next;

  assign faddr  = ir_reg[7:0];
  assign at_end = (phase_reg == oapl_pkg::OAPL_PH_WRITE);
  assign is_or  = (instr[15:12] == oapl_pkg::OP_OR_HI) &&
                  (instr[11:10] == oapl_pkg::OP_OR_MID);
  // selector 3 decodes as no instruction at all
  assign is_ptr = (instr[15:8] == oapl_pkg::OP_PTR_HI) &&
                  (instr[7:6] == oapl_pkg::OP_PTR_MID) &&
                  (instr[5:4] != oapl_pkg::PTR_COUNT);
  assign is_w2  = (instr[15:8] == oapl_pkg::OP_PTR_W2_HI);
  assign phase  = phase_reg;
  assign busy   = (state_reg != oapl_pkg::OAPL_IDLE);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg <= oapl_pkg::OAPL_PH_DECODE;
    end else begin
      phase_reg <= oapl_pkg::oapl_phase_t'(phase_reg + 2'h1);
    end
  end

  // a new word is only decoded at the decode phase
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      oapl_pkg::OAPL_IDLE, oapl_pkg::OAPL_OR: begin
        if (at_end) begin
          state_next = oapl_pkg::OAPL_IDLE;
        end
        if (phase_reg == oapl_pkg::OAPL_PH_DECODE && instr_valid) begin
          if (is_or) begin
            state_next = oapl_pkg::OAPL_OR;
          end else if (is_ptr) begin
            state_next = oapl_pkg::OAPL_PTR1;
          end else begin
            state_next = oapl_pkg::OAPL_IDLE;
          end
        end
      end
      oapl_pkg::OAPL_PTR1: begin
        if (at_end) begin
          state_next = oapl_pkg::OAPL_PTR2;
        end
      end
      oapl_pkg::OAPL_PTR2: begin
        if (at_end) begin
          state_next = oapl_pkg::OAPL_IDLE;
        end
      end
      default: state_next = oapl_pkg::OAPL_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= oapl_pkg::OAPL_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // second pointer word latched at its own decode phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ir_reg <= 16'h0000;
    end else if (phase_reg == oapl_pkg::OAPL_PH_DECODE &&
                 (instr_valid || state_reg == oapl_pkg::OAPL_PTR2)) begin
      ir_reg <= instr;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      illegal <= 1'b0;
    end else if (phase_reg == oapl_pkg::OAPL_PH_DECODE) begin
      illegal <= (state_reg == oapl_pkg::OAPL_PTR2) ? !is_w2 : 1'b0;
    end
  end

  // bank select only for banked access, indexed mode for low offsets
  always_comb begin
    addr_next = 12'h000;
    if (ir_reg[oapl_pkg::ACC_BIT]) begin
      addr_next = {bank_select_register, faddr};
    end else if (extended_enable && faddr <= oapl_pkg::INDEXED_LIMIT) begin
      addr_next = 12'(ptrs[2] + {4'h0, faddr});
    end else if (faddr < oapl_pkg::ACCESS_SPLIT) begin
      addr_next = {oapl_pkg::ACCESS_BANK_LO, faddr};
    end else begin
      addr_next = {oapl_pkg::ACCESS_BANK_HI, faddr};
    end
  end

  // loaded at the end of the read phase and held, so the memory answer settles in phase 2
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      file_addr <= 12'h000;
    end else if (state_reg == oapl_pkg::OAPL_OR && phase_reg == oapl_pkg::OAPL_PH_READ) begin
      file_addr <= addr_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_reg <= 8'h00;
    end else if (state_reg == oapl_pkg::OAPL_OR && phase_reg == oapl_pkg::OAPL_PH_PROC) begin
      result_reg <= work_reg | file_rdata;
    end
  end

  assign file_wdata = result_reg;
  // strobe only in the last phase, address and data already settled
  assign file_we = (state_reg == oapl_pkg::OAPL_OR) && at_end &&
                   ir_reg[oapl_pkg::DIR_BIT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      work_reg <= oapl_pkg::WORK_RESET;
    end else if (state_reg == oapl_pkg::OAPL_OR && at_end && !ir_reg[oapl_pkg::DIR_BIT]) begin
      work_reg <= result_reg;
    end
  end

  // pointer load leaves the flags alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_negative <= 1'b0;
      flag_zero     <= 1'b0;
    end else if (state_reg == oapl_pkg::OAPL_OR && at_end) begin
      flag_negative <= result_reg[7];
      flag_zero     <= (result_reg == 8'h00);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_reg <= 2'h0;
    end else if (state_reg == oapl_pkg::OAPL_PTR1 && phase_reg == oapl_pkg::OAPL_PH_READ) begin
      sel_reg <= ir_reg[5:4];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      khigh_reg <= 4'h0;
    end else if (state_reg == oapl_pkg::OAPL_PTR1 && phase_reg == oapl_pkg::OAPL_PH_READ) begin
      khigh_reg <= ir_reg[3:0];
    end
  end

  // low byte held back if the second word is malformed
  for (genvar i = 0; i < 3; i++) begin : g_ptr
    assign ld_hi[i] = (state_reg == oapl_pkg::OAPL_PTR1) && at_end &&
                      (sel_reg == 2'(i));
    assign ld_lo[i] = (state_reg == oapl_pkg::OAPL_PTR2) && at_end &&
                      (sel_reg == 2'(i)) && !illegal;
    oapl_ptr_reg u_ptr (
      .clk       (clk),
      .rst       (rst),
      .load_high (ld_hi[i]),
      .load_low  (ld_lo[i]),
      .high_in   (khigh_reg),
      .low_in    (ir_reg[7:0]),
      .ptr       (ptrs[i])
    );
  end

  assign indirect_pointer0 = ptrs[0];
  assign indirect_pointer1 = ptrs[1];
  assign indirect_pointer2 = ptrs[2];
endmodule // oapl_core
`default_nettype wire

// file: oapl_core_monitor.sv
/* checker for oapl_core: or-into-file and pointer-load timing at the ports
   assumes a free-running phase count, take at the phase 0 edge */
`default_nettype none
module oapl_core_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] instr,
  input wire logic        instr_valid,
  input wire logic [3:0]  bank_select_register,
  input wire logic        extended_enable,
  input wire logic [7:0]  file_rdata,
  input wire logic [11:0] file_addr,
  input wire logic [7:0]  file_wdata,
  input wire logic        file_we,
  input wire logic [7:0]  work_reg,
  input wire logic        flag_negative,
  input wire logic        flag_zero,
  input wire logic [11:0] indirect_pointer0,
  input wire logic [11:0] indirect_pointer1,
  input wire logic [11:0] indirect_pointer2,
  input wire logic [1:0]  phase,
  input wire logic        busy,
  input wire logic        illegal
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic        second_q;
  logic [15:0] word_q;
  logic [7:0]  low_q;
  wire logic go = phase == 2'h0 && instr_valid && !second_q;
  wire logic or_go = go && instr[15:10] == {oapl_pkg::OP_OR_HI, oapl_pkg::OP_OR_MID};
  // selector 3 is refused, so it opens no second word
  wire logic ptr_go = go && instr[15:8] == oapl_pkg::OP_PTR_HI && instr[7:4] < 4'h3;
  wire logic [11:0] sel_ptr = word_q[5:4] == 2'h0 ? indirect_pointer0 :
                              word_q[5:4] == 2'h1 ? indirect_pointer1 : indirect_pointer2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      second_q <= 1'b0;
      word_q <= 16'h0000;
      low_q <= 8'h00;
    end else if (phase == 2'h0) begin
      second_q <= ptr_go;
      if (go) word_q <= instr;
      if (second_q) low_q <= instr[7:0];
    end
  end
  a_or_to_work: assert property (or_go && !instr[9] |-> ##3 !file_we ##1
    work_reg == ($past(work_reg, 2) | $past(file_rdata, 2)) &&
    flag_zero == (work_reg == 8'h00) && flag_negative == work_reg[7])
    else $error("or result into work wrong");
  a_or_to_file: assert property (or_go && instr[9] |-> ##3 file_we &&
    file_wdata == ($past(work_reg) | $past(file_rdata)) ##1 work_reg == $past(work_reg))
    else $error("or result into file wrong");
  a_we_in_phase: assert property (file_we |-> phase == oapl_pkg::PHASE_LAST &&
    $past(or_go, 3)) else $error("file write outside phase 3");
  a_access_bank: assert property (or_go && !instr[8] &&
    !(extended_enable && instr[7:0] <= oapl_pkg::INDEXED_LIMIT) |-> ##2
    file_addr == {(word_q[7:0] < oapl_pkg::ACCESS_SPLIT) ? oapl_pkg::ACCESS_BANK_LO :
    oapl_pkg::ACCESS_BANK_HI, word_q[7:0]}) else $error("access bank address wrong");
  a_bank_select: assert property (or_go && instr[8] |-> ##2
    file_addr == {bank_select_register, word_q[7:0]}) else $error("banked address wrong");
  a_indexed_mode: assert property (or_go && !instr[8] && extended_enable &&
    instr[7:0] <= oapl_pkg::INDEXED_LIMIT |-> ##2
    file_addr == indirect_pointer2 + {4'h0, word_q[7:0]}) else $error("indexed address wrong");
  a_ptr_high: assert property (ptr_go |-> ##4 sel_ptr[11:8] == word_q[3:0] &&
    flag_zero == $past(flag_zero, 4) && flag_negative == $past(flag_negative, 4))
    else $error("pointer high nibble or flags wrong");
  a_ptr_low: assert property (second_q && phase == 2'h0 &&
    instr[15:8] == oapl_pkg::OP_PTR_W2_HI |-> ##4 sel_ptr[7:0] == low_q && !illegal)
    else $error("pointer low byte wrong");
  a_bad_second: assert property (second_q && phase == 2'h0 &&
    instr[15:8] != oapl_pkg::OP_PTR_W2_HI |-> ##1 illegal ##3 sel_ptr == $past(sel_ptr, 4))
    else $error("malformed second word not refused");
  a_or_busy: assert property (or_go |-> ##1 busy[*3] ##1 !busy)
    else $error("busy wrong around or instruction");
  a_ptr_busy: assert property (ptr_go |-> ##1 busy[*7] ##1 !busy)
    else $error("busy wrong around pointer load");
endmodule // oapl_core_monitor
bind oapl_core oapl_core_monitor u_oapl_core_monitor (.clk, .rst, .instr, .instr_valid,
  .bank_select_register, .extended_enable, .file_rdata, .file_addr, .file_wdata, .file_we,
  .work_reg, .flag_negative, .flag_zero, .indirect_pointer0, .indirect_pointer1,
  .indirect_pointer2, .phase, .busy, .illegal);
`default_nettype wire

// file: oapl_core_tb.sv
/* bench for oapl_core: pointer loads, then or-into-file in every mode
   assumes file memory answers combinationally with a fixed pattern */
`default_nettype none
module oapl_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, instr_valid, extended_enable, file_we, flag_negative, flag_zero, busy, illegal;
  logic [15:0] instr;
  logic [3:0]  bank_select_register;
  logic [7:0]  file_rdata, file_wdata, work_reg, work_exp;
  logic [11:0] file_addr, indirect_pointer0, indirect_pointer1, indirect_pointer2;
  logic [1:0]  phase;
  int          fail_count, num_checks;
  function automatic logic [7:0] mem_at(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h35;
  endfunction
  function automatic logic [11:0] ptr_of(input logic [1:0] s);
    return s == 2'h0 ? indirect_pointer0 : s == 2'h1 ? indirect_pointer1 : indirect_pointer2;
  endfunction
  assign file_rdata = mem_at(file_addr);
  oapl_core u_oapl_core (.clk, .rst, .instr, .instr_valid, .bank_select_register,
    .extended_enable, .file_rdata, .file_addr, .file_wdata, .file_we, .work_reg,
    .flag_negative, .flag_zero, .indirect_pointer0, .indirect_pointer1,
    .indirect_pointer2, .phase, .busy, .illegal);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task test_done;
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  // words only go in at a phase 0 edge; a stuck phase ends the run
  task step(input logic [15:0] w);
    for (int i = 0; i < 8 && phase !== 2'h0; i++) tick();
    if (phase !== 2'h0) begin
      chk({10'h000, phase}, 12'h000);
      test_done();
    end
    instr = w;
    instr_valid = 1'b1;
    tick();
    instr_valid = 1'b0;
  endtask
  task ptr(input logic [1:0] s, input logic [11:0] k, input logic [7:0] w2);
    logic [11:0] old, keep;
    old = ptr_of(s);
    keep = {2'h0, flag_negative, flag_zero, work_reg};
    step({8'hEE, 2'h0, s, k[11:8]});
    tick();
    tick();
    tick();
    chk(ptr_of(s), {k[11:8], old[7:0]});
    chk({11'h000, busy}, 12'h001);
    step({w2, k[7:0]});
    tick();
    tick();
    tick();
    chk(ptr_of(s), w2 == 8'hF0 ? k : {k[11:8], old[7:0]});
    chk({11'h000, illegal}, {11'h000, w2 != 8'hF0});
    chk({11'h000, busy}, 12'h000);
    chk({2'h0, flag_negative, flag_zero, work_reg}, keep);
  endtask
  task orf(input logic [15:0] w, input logic [11:0] a);
    logic [7:0] r;
    r = work_exp | mem_at(a);
    step(w);
    tick();
    tick();
    chk(file_addr, a);
    chk({11'h000, file_we}, {11'h000, w[9]});
    chk({4'h0, file_wdata}, {4'h0, r});
    chk({11'h000, busy}, 12'h001);
    chk({10'h000, phase}, {10'h000, oapl_pkg::PHASE_LAST});
    tick();
    if (!w[9]) work_exp = r;
    chk({11'h000, busy}, 12'h000);
    chk({2'h0, flag_negative, flag_zero, work_reg}, {2'h0, r[7], r == 8'h00, work_exp});
  endtask
  initial begin
    fail_count = 0;
    num_checks = 0;
    rst = 1'b1;
    instr = 16'h0000;
    instr_valid = 1'b0;
    bank_select_register = 4'hC;
    extended_enable = 1'b0;
    work_exp = 8'h00;
    tick();
    tick();
    rst = 1'b0;
    ptr(2'h0, 12'hABC, 8'hF0);
    ptr(2'h1, 12'h5A5, 8'hF0);
    ptr(2'h2, 12'h3AB, 8'hF0);
    ptr(2'h1, 12'h7FF, 8'hE0);
    step(16'hEE35);
    chk({11'h000, busy}, 12'h000);
    chk(indirect_pointer2, 12'h3AB);
    orf(16'h1035, 12'h035);
    orf(16'h1112, 12'hC12);
    orf(16'h1280, 12'hF80);
    orf(16'h105F, 12'h05F);
    extended_enable = 1'b1;
    orf(16'h105F, 12'h40A);
    orf(16'h1060, 12'hF60);
    orf(16'h1110, 12'hC10);
    orf(16'h1360, 12'hC60);
    test_done();
  end
endmodule // oapl_core_tb
`default_nettype wire
